// >>> src/mwi_slave.sv
// memory window serial slave: two addresses, each a byte buffer behind a base index
// assumes scl/sda arrive from pins; buffer owner answers reads and drains writes on clk_sys
`timescale 1ns/1ps
`include "mwi_cfg.svh"
module mwi_slave (
	input wire logic clk_sys, // block clock, 125 MHz
	input wire logic nrst, // synchronous reset, low active
	input wire logic ce, // clock enable
	input wire logic scl_i, // clock line level
	output logic scl_o, // clock line drive value, always low
	output logic scl_oe, // high while holding the clock line low
	input wire logic sda_i, // data line level
	output logic sda_o, // data line drive value, always low
	output logic sda_oe, // high while pulling the data line low
	input wire mwi_pkg::mwi_win_t win0, // primary address window
	input wire mwi_pkg::mwi_win_t win1, // secondary address window
	input wire logic win1_en, // secondary address answered
	input wire logic idx16, // base index is two bytes wide
	input wire logic stretch_en, // clock stretching allowed
	output logic wr_valid, // accepted write waiting
	input wire logic wr_ready, // buffer owner takes the write
	output mwi_pkg::mwi_wr_t wr_data, // buffer, index and byte
	output logic rd_req, // one-cycle read request
	output logic rd_buf, // buffer of the read
	output logic [15:0] rd_index, // offset of the read
	input wire logic [7:0] rd_data, // byte answered
	input wire logic rd_valid, // one-cycle answer strobe
	output logic busy // slave addressed or receiving
);
	mwi_pkg::mwi_state_t state_r;
	mwi_pkg::mwi_kind_t kind_r;
	logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
	logic [3:0] bitcnt_r;
	logic [7:0] sh_r, hi_r, tx_r;
	logic sel_r, rw_r, nack_r, need_r, txok_r;
	logic [15:0] base0_r, base1_r, ptr_r;
	mwi_pkg::mwi_wr_t pend_r;
	logic rd_req_r, rd_buf_r, busy_r, scl_oe_r, sda_oe_r;
	logic [15:0] rd_index_r;
	logic fifo_in_ready;

	// offset lies below a bound; used for write region and read range
	function automatic logic mwi_below(input logic [15:0] idx, input logic [15:0] bound);
		return idx < bound;
	endfunction

	// bus events seen through the synchronised lines
	wire rise = scl_s2_r & ~scl_d_r;
	wire fall = ~scl_s2_r & scl_d_r;
	wire start_c = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	wire stop_c = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
	wire byte_done = (state_r == mwi_pkg::ST_RXB) && fall && (bitcnt_r == `MWI_BYTE_BITS);

	// address match on 7-bit values, primary wins a tie
	wire match0 = (sh_r[7:1] == win0.addr);
	wire match1 = win1_en && (sh_r[7:1] == win1.addr);
	wire hit = match0 | match1;
	wire [15:0] cur_len = sel_r ? win1.buffer_length : win0.buffer_length;
	wire [15:0] cur_lim = sel_r ? win1.writable_limit : win0.writable_limit;
	wire [15:0] new_base = idx16 ? {hi_r, sh_r} : {`MWI_HI_PAD, sh_r};
	wire wr_ok = mwi_below(ptr_r, cur_lim) && mwi_below(ptr_r, cur_len);
	wire data_done = byte_done && (kind_r == mwi_pkg::K_DATA);
	wire addr_rd = byte_done && (kind_r == mwi_pkg::K_ADDR) && hit && sh_r[0];
	wire fetch_go = addr_rd || ((state_r == mwi_pkg::ST_TACK) && rise && !sda_s2_r);
	wire [15:0] rd_base = match0 ? base0_r : base1_r;

	// write path: direct from the receive shifter, or the held byte while stretching
	wire in_str_wr = (state_r == mwi_pkg::ST_STR) && !rw_r;
	wire push = fifo_in_ready && ((data_done && wr_ok) || in_str_wr);
	wire mwi_pkg::mwi_wr_t cur_wr = '{buf_sel: sel_r, index: ptr_r, data: sh_r};
	wire mwi_pkg::mwi_wr_t push_data = in_str_wr ? pend_r : cur_wr;

	// sending side: next byte is loaded at the end of an ack
	wire ack_end_rd = fall && !nack_r && rw_r && ((state_r == mwi_pkg::ST_ACK) || (state_r == mwi_pkg::ST_TACK));
	wire tx_wait = !txok_r && stretch_en;
	wire tx_load = (ack_end_rd && !tx_wait) || ((state_r == mwi_pkg::ST_STR) && rw_r && !tx_wait);
	wire mwi_pkg::mwi_kind_t kind_after = (kind_r == mwi_pkg::K_ADDR) ? (idx16 ? mwi_pkg::K_IHI : mwi_pkg::K_ILO) :
		(kind_r == mwi_pkg::K_IHI) ? mwi_pkg::K_ILO : mwi_pkg::K_DATA;

	mwi_fifo #(.W($bits(mwi_pkg::mwi_wr_t)), .D(`MWI_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(wr_data)
	);

	// two-flop synchronisers and one delayed copy for edge finding
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			{scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
			{sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
		end else if (ce) begin
			{scl_s1_r, scl_s2_r, scl_d_r} <= {scl_i, scl_s1_r, scl_s2_r};
			{sda_s1_r, sda_s2_r, sda_d_r} <= {sda_i, sda_s1_r, sda_s2_r};
		end
	end

	// bus state machine, pointer and base indices
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_r <= mwi_pkg::ST_IDLE;
			kind_r <= mwi_pkg::K_ADDR;
			bitcnt_r <= 4'h0;
			sh_r <= 8'h00;
			hi_r <= 8'h00;
			sel_r <= 1'b0;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			ptr_r <= `MWI_RST_INDEX;
			base0_r <= `MWI_RST_INDEX;
			base1_r <= `MWI_RST_INDEX;
			pend_r <= '0;
		end else if (ce) begin
			if (start_c) begin
				state_r <= mwi_pkg::ST_RXB;
				kind_r <= mwi_pkg::K_ADDR;
				bitcnt_r <= 4'h0;
			end else if (stop_c) begin
				state_r <= mwi_pkg::ST_IDLE;
			end else if (tx_load) begin
				sh_r <= tx_r;
				bitcnt_r <= 4'h0;
				ptr_r <= ptr_r + 16'h0001;
				state_r <= mwi_pkg::ST_TXB;
			end else begin
				case (state_r)
					mwi_pkg::ST_RXB: begin
						if (rise) begin
							sh_r <= {sh_r[6:0], sda_s2_r};
							bitcnt_r <= bitcnt_r + 4'h1;
						end else if (byte_done) begin
							state_r <= mwi_pkg::ST_ACK;
							nack_r <= 1'b0;
							case (kind_r)
								mwi_pkg::K_ADDR: begin
									nack_r <= !hit;
									rw_r <= sh_r[0];
									sel_r <= !match0;
									if (sh_r[0])
										ptr_r <= rd_base;
								end
								mwi_pkg::K_IHI: hi_r <= sh_r;
								mwi_pkg::K_ILO: begin
									ptr_r <= new_base;
									if (sel_r)
										base1_r <= new_base;
									else
										base0_r <= new_base;
								end
								default: begin
									ptr_r <= ptr_r + 16'h0001;
									pend_r <= cur_wr;
									if (!wr_ok)
										nack_r <= stretch_en;
									else if (!fifo_in_ready && stretch_en)
										state_r <= mwi_pkg::ST_STR;
								end
							endcase
						end
					end
					mwi_pkg::ST_ACK: begin
						if (fall && nack_r)
							state_r <= mwi_pkg::ST_IDLE;
						else if (fall && rw_r)
							state_r <= mwi_pkg::ST_STR;
						else if (fall) begin
							state_r <= mwi_pkg::ST_RXB;
							kind_r <= kind_after;
							bitcnt_r <= 4'h0;
						end
					end
					mwi_pkg::ST_TXB: begin
						if (fall && bitcnt_r == `MWI_LAST_BIT)
							state_r <= mwi_pkg::ST_TACK;
						else if (fall) begin
							sh_r <= {sh_r[6:0], 1'b1};
							bitcnt_r <= bitcnt_r + 4'h1;
						end
					end
					mwi_pkg::ST_TACK: begin
						if (rise && sda_s2_r)
							state_r <= mwi_pkg::ST_IDLE;
						else if (fall)
							state_r <= mwi_pkg::ST_STR;
					end
					mwi_pkg::ST_STR: begin
						if (!rw_r && (fifo_in_ready || !stretch_en))
							state_r <= mwi_pkg::ST_ACK;
					end
					default: state_r <= mwi_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// fetch of the next byte to send; beyond the buffer end the filler is used
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			need_r <= 1'b0;
			txok_r <= 1'b0;
			tx_r <= `MWI_FILLER;
			rd_req_r <= 1'b0;
			rd_buf_r <= 1'b0;
			rd_index_r <= `MWI_RST_INDEX;
		end else if (ce) begin
			rd_req_r <= 1'b0;
			if (need_r && mwi_below(ptr_r, cur_len)) begin
				rd_req_r <= 1'b1;
				rd_buf_r <= sel_r;
				rd_index_r <= ptr_r;
				txok_r <= 1'b0;
			end else if (need_r) begin
				tx_r <= `MWI_FILLER;
				txok_r <= 1'b1;
			end else if (rd_valid) begin
				tx_r <= rd_data;
				txok_r <= 1'b1;
			end
			need_r <= fetch_go;
		end
	end

	// line drivers: pull data low for ack or a zero bit, hold clock in the pause state
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (ce) begin
			sda_oe_r <= ((state_r == mwi_pkg::ST_ACK) && !nack_r) || ((state_r == mwi_pkg::ST_TXB) && !sh_r[7]);
			scl_oe_r <= (state_r == mwi_pkg::ST_STR) && stretch_en;
			busy_r <= (state_r != mwi_pkg::ST_IDLE);
		end
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;
	assign rd_req = rd_req_r;
	assign rd_buf = rd_buf_r;
	assign rd_index = rd_index_r;
	assign busy = busy_r;

	// checks beside the logic
	a_base_reset_zero: assert property (@(posedge clk_sys) $rose(nrst) |-> base0_r == 16'h0000 && base1_r == 16'h0000)
		else $error("base index not zero after reset");
	a_oob_nack_on: assert property (@(posedge clk_sys) disable iff (!nrst) ce && data_done && !wr_ok && stretch_en
		|-> !push ##1 nack_r && state_r == mwi_pkg::ST_ACK)
		else $error("out of region byte not refused");
	a_oob_drop_off: assert property (@(posedge clk_sys) disable iff (!nrst) ce && data_done && !wr_ok && !stretch_en
		|-> !push ##1 !nack_r ##1 sda_oe_r || !ce || start_c || stop_c)
		else $error("out of region byte not acked or stored");
	a_ptr_adv_write: assert property (@(posedge clk_sys) disable iff (!nrst) ce && data_done && !start_c && !stop_c
		|=> ptr_r == $past(ptr_r) + 16'h0001)
		else $error("write pointer did not advance");
	a_read_from_base: assert property (@(posedge clk_sys) disable iff (!nrst) ce && addr_rd && !start_c && !stop_c
		|=> ptr_r == (sel_r ? base1_r : base0_r) && need_r)
		else $error("read does not start at base index");
	a_base_kept_tx: assert property (@(posedge clk_sys) disable iff (!nrst) state_r == mwi_pkg::ST_TXB
		|=> $stable(base0_r) && $stable(base1_r))
		else $error("base index changed by a read");
	a_filler_past_end: assert property (@(posedge clk_sys) disable iff (!nrst) ce && need_r && !mwi_below(ptr_r, cur_len)
		|=> tx_r == `MWI_FILLER && txok_r && !rd_req_r)
		else $error("filler not returned past end");
	a_no_stretch_off: assert property (@(posedge clk_sys) disable iff (!nrst) !stretch_en && $past(stretch_en) == 1'b0
		|-> !scl_oe_r)
		else $error("clock held while stretching off");
	a_index_hi_first: assert property (@(posedge clk_sys) disable iff (!nrst) ce && byte_done && kind_r == mwi_pkg::K_ILO
		&& idx16 && !sel_r && !start_c && !stop_c |=> base0_r == {$past(hi_r), $past(sh_r)})
		else $error("two-byte index assembled in wrong order");
	a_write_in_region: assert property (@(posedge clk_sys) disable iff (!nrst) push && !in_str_wr
		|-> push_data.index < cur_lim && push_data.index < cur_len)
		else $error("write stored outside region");
endmodule // mwi_slave

// >>> inc/mwi_cfg.svh
// constants for the memory window serial slave
// assumes inclusion by bare name from the slave and fifo modules
`ifndef MWI_CFG_SVH
`define MWI_CFG_SVH
`define MWI_FILLER 8'hff
`define MWI_RST_INDEX 16'h0000
`define MWI_FIFO_DEPTH 4
`define MWI_LAST_BIT 4'h7
`define MWI_BYTE_BITS 4'h8
`define MWI_HI_PAD 8'h00
`endif

// >>> inc/mwi_pkg.sv
// types shared by the memory window serial slave and its write fifo
// assumes nothing beyond a SystemVerilog compiler
package mwi_pkg;
	// bus state machine, gray coded along idle, receive, ack, send, master ack
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RXB = 3'h1,
		ST_ACK = 3'h3,
		ST_TXB = 3'h2,
		ST_TACK = 3'h6,
		ST_STR = 3'h7
	} mwi_state_t;
	// meaning of the byte being received
	typedef enum logic [1:0] {
		K_ADDR = 2'h0,
		K_IHI = 2'h1,
		K_ILO = 2'h3,
		K_DATA = 2'h2
	} mwi_kind_t;
	// one accepted write, handed to the buffer owner
	typedef struct packed {
		logic buf_sel;
		logic [15:0] index;
		logic [7:0] data;
	} mwi_wr_t;
	// one address window: slave address and buffer geometry
	typedef struct packed {
		logic [6:0] addr;
		logic [15:0] buffer_length;
		logic [15:0] writable_limit;
	} mwi_win_t;
endpackage

// >>> src/mwi_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes depth is a power of two; one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "mwi_cfg.svh"
module mwi_fifo #(
	parameter int W = 25,
	parameter int D = `MWI_FIFO_DEPTH
) (
	input wire logic clk_sys, // block clock
	input wire logic nrst, // synchronous reset, low active
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic in_valid, // producer offers a word
	output logic in_ready, // room for a word
	input wire logic [W-1:0] in_data, // word offered
	output logic out_valid, // word available
	input wire logic out_ready, // consumer takes the word
	output logic [W-1:0] out_data // oldest word
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// flags come straight from the occupancy count
	assign in_ready = (cnt_r != FULL);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rp_r];

	// pointers and count
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			if (push) begin
				mem[wp_r] <= in_data;
				wp_r <= wp_r + 1'b1;
			end
			if (pop)
				rp_r <= rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule // mwi_fifo

// >>> testbench/mwi_master.sv
// i2c bus master model that drives open-drain clock and data lines for the serial slave
// assumes pull-ups on both lines; it paces its bits in time, 125 ns to a bit, off the bench clock edges
`timescale 1ns/1ps
module mwi_master (
	input wire logic clk_sys, // bench clock
	input wire logic scl_line, // resolved clock line
	input wire logic sda_line, // resolved data line
	output logic scl_m, // master clock drive, low pulls the line
	output logic sda_m, // master data drive, low pulls the line
	output logic hung // a stretch wait ran out
);
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
		hung = 1'b0;
	end
	// release the clock, then wait while the slave holds it low; resumes half a nanosecond off an edge
	task automatic rise();
		int k;
		k = 0;
		scl_m = 1'b1;
		#1;
		while (!scl_line && k < 3000) begin
			k++;
			@(posedge clk_sys);
			#0.5;
		end
		if (k >= 3000)
			hung = 1'b1;
	endtask
	// one bit out and one bit back in 125 ns, sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		#24;
		sda_m = b;
		#38;
		rise();
		#55;
		r = sda_line;
		#7;
		scl_m = 1'b0;
	endtask
	// start or repeated start; aligned half a nanosecond after an edge so no line moves on an edge
	task automatic start();
		@(posedge clk_sys);
		#0.5;
		sda_m = 1'b1;
		#64;
		rise();
		#59;
		sda_m = 1'b0;
		#64;
		scl_m = 1'b0;
	endtask
	// stop: data falls while the clock is low, then rises while it is high
	task automatic stop();
		#24;
		sda_m = 1'b0;
		#40;
		rise();
		#59;
		sda_m = 1'b1;
		#64;
	endtask
	// eight bits msb first, then the acknowledge bit in either direction
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, ack);
	endtask
endmodule // mwi_master

// >>> testbench/memory_window_i2c_slave_tb.sv
// self-checking bench for the memory window serial slave
// assumes the master model; the bench plays the buffer owner with a shadow of expected contents
`timescale 1ns/1ps
module memory_window_i2c_slave_tb;
	logic clk_sys, nrst, ce, win1_en, idx16, stretch_en, wr_ready, rd_valid, hold, hung, saw_str;
	logic scl_oe, sda_oe, scl_m, sda_m, scl_line, sda_line, wr_valid, rd_req, rd_buf, busy;
	logic [15:0] rd_index;
	logic [7:0] rd_data;
	mwi_pkg::mwi_win_t win0, win1;
	mwi_pkg::mwi_wr_t wr_data;
	logic [7:0] mem [2][512];
	logic [7:0] shadow [2][512];
	int errors, num_checks;
	// open-drain lines with pull-ups
	assign scl_line = scl_m & ~scl_oe;
	assign sda_line = sda_m & ~sda_oe;
	mwi_slave u_mwi_slave (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .scl_i(scl_line), .scl_o(), .scl_oe(scl_oe),
		.sda_i(sda_line), .sda_o(), .sda_oe(sda_oe), .win0(win0), .win1(win1), .win1_en(win1_en), .idx16(idx16),
		.stretch_en(stretch_en), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_req(rd_req),
		.rd_buf(rd_buf), .rd_index(rd_index), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy));
	mwi_master u_mwi_master (.clk_sys(clk_sys), .scl_line(scl_line), .sda_line(sda_line), .scl_m(scl_m),
		.sda_m(sda_m), .hung(hung));
	// buffer owner: answers a read one cycle later, drains writes unless held
	always @(posedge clk_sys) begin
		rd_valid <= rd_req;
		if (rd_req)
			rd_data <= mem[rd_buf][rd_index[8:0]];
		wr_ready <= !hold;
		if (wr_valid && wr_ready)
			mem[wr_data.buf_sel][wr_data.index[8:0]] <= wr_data.data;
		if (scl_oe)
			saw_str <= 1'b1;
		if (hung) begin
			errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// write with index then n bytes; each ack judged against the region, stop after a refusal
	task automatic wr_seq(input logic [6:0] a, input logic b, input logic [15:0] idx, input int n);
		logic [7:0] q, d;
		logic ack, ok;
		mwi_pkg::mwi_win_t w;
		int t;
		w = b ? win1 : win0;
		u_mwi_master.start();
		u_mwi_master.xfer({a, 1'b0}, 1'b1, q, ack);
		chk(ack, 1'b0);
		if (idx16)
			u_mwi_master.xfer(idx[15:8], 1'b1, q, ack);
		u_mwi_master.xfer(idx[7:0], 1'b1, q, ack);
		for (int k = 0; k < n; k++) begin
			ok = (idx + k < w.writable_limit) && (idx + k < w.buffer_length);
			d = 8'h30 + idx[7:0] + 8'(k);
			u_mwi_master.xfer(d, 1'b1, q, ack);
			chk(ack, !ok && stretch_en);
			if (ok)
				shadow[b][idx + k] = d;
			if (ack)
				break;
		end
		u_mwi_master.stop();
		t = 0;
		while (wr_valid && t < 3000) begin
			t++;
			@(posedge clk_sys);
		end
		if (t >= 3000) begin
			errors++;
			conclude();
		end
	endtask
	// read n bytes; expected run from the base index into filler past the end
	task automatic rd_seq(input logic [6:0] a, input logic b, input logic [15:0] idx, input int n);
		logic [7:0] q;
		logic ack;
		mwi_pkg::mwi_win_t w;
		w = b ? win1 : win0;
		u_mwi_master.start();
		u_mwi_master.xfer({a, 1'b1}, 1'b1, q, ack);
		chk(ack, 1'b0);
		chk(busy, 1'b1);
		for (int k = 0; k < n; k++) begin
			u_mwi_master.xfer(8'hff, k == n - 1, q, ack);
			chk(q, (idx + k < w.buffer_length) ? shadow[b][idx + k] : 8'hff);
		end
		u_mwi_master.stop();
		chk(busy, 1'b0);
	endtask
	task automatic t_reset();
		chk({busy, sda_oe, scl_oe, wr_valid, rd_req}, 5'h00);
		rd_seq(7'h12, 1'b0, 16'h0000, 2);
		$display("done: reset");
	endtask
	task automatic t_wr_rd();
		wr_seq(7'h12, 1'b0, 16'h0002, 3);
		rd_seq(7'h12, 1'b0, 16'h0002, 4);
		rd_seq(7'h12, 1'b0, 16'h0002, 4);
		wr_seq(7'h12, 1'b0, 16'h0004, 0);
		rd_seq(7'h12, 1'b0, 16'h0004, 2);
		$display("done: write then read");
	endtask
	task automatic t_idx16();
		@(posedge clk_sys);
		idx16 <= 1'b1;
		wr_seq(7'h34, 1'b1, 16'h012a, 2);
		rd_seq(7'h34, 1'b1, 16'h012a, 4);
		rd_seq(7'h12, 1'b0, 16'h0004, 1);
		$display("done: two-byte index");
	endtask
	task automatic t_refuse();
		@(posedge clk_sys);
		idx16 <= 1'b0;
		stretch_en <= 1'b1;
		wr_seq(7'h12, 1'b0, 16'h0007, 3);
		@(posedge clk_sys);
		stretch_en <= 1'b0;
		saw_str <= 1'b0;
		wr_seq(7'h12, 1'b0, 16'h0006, 4);
		chk(saw_str, 1'b0);
		rd_seq(7'h12, 1'b0, 16'h0006, 12);
		$display("done: refused writes");
	endtask
	// reset in mid-run: the primary base index was moved away from zero and must come back to it
	task automatic t_rst_mid();
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		chk({busy, sda_oe, scl_oe, wr_valid, rd_req}, 5'h00);
		rd_seq(7'h12, 1'b0, 16'h0000, 2);
		$display("done: reset in mid-run");
	endtask
	task automatic t_noaddr();
		logic [7:0] q;
		logic ack;
		@(posedge clk_sys);
		win1_en <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			u_mwi_master.start();
			u_mwi_master.xfer({(i == 1) ? 7'h55 : 7'h34, 1'b0}, 1'b1, q, ack);
			chk(ack, 1'b1);
			u_mwi_master.stop();
		end
		@(posedge clk_sys);
		win1_en <= 1'b1;
		$display("done: unmatched address");
	endtask
	task automatic t_fifo();
		@(posedge clk_sys);
		idx16 <= 1'b1;
		stretch_en <= 1'b1;
		hold <= 1'b1;
		saw_str <= 1'b0;
		fork
			begin
				repeat (1500) @(posedge clk_sys);
				hold <= 1'b0;
			end
		join_none
		wr_seq(7'h34, 1'b1, 16'h0000, 6);
		chk(saw_str, 1'b1);
		rd_seq(7'h34, 1'b1, 16'h0000, 6);
		$display("done: fifo full stretch");
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// watchdog over the whole run
	initial begin
		repeat (100000) @(posedge clk_sys);
		errors++;
		conclude();
	end
	initial begin
		errors = 0;
		num_checks = 0;
		nrst = 1'b0;
		ce = 1'b1;
		win1_en = 1'b1;
		idx16 = 1'b0;
		stretch_en = 1'b0;
		hold = 1'b0;
		saw_str = 1'b0;
		rd_data = 8'h00;
		win0 = '{7'h12, 16'h0010, 16'h0008};
		win1 = '{7'h34, 16'h012c, 16'h012c};
		for (int i = 0; i < 2; i++) begin
			for (int j = 0; j < 512; j++) begin
				mem[i][j] = 8'(j * 7 + i * 64);
				shadow[i][j] = 8'(j * 7 + i * 64);
			end
		end
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_wr_rd();
		t_idx16();
		t_refuse();
		t_rst_mid();
		t_noaddr();
		t_fifo();
		conclude();
	end
endmodule // memory_window_i2c_slave_tb
